// ===== rtl/fpg_cfg.svh
// Offsets, field positions, reset values and sizes of the flash partition guard.
`ifndef FPG_CFG_SVH
`define FPG_CFG_SVH
`define FPG_ADDR_W         15
`define FPG_BOOT_START     15'h0000
`define FPG_STORE_SPAN     15'h0080
`define FPG_STORE_TOP_OFS  15'h007F
`define FPG_PFM_LAST       15'h1FFF
`define FPG_CFG_BASE       15'h7FF0
`define FPG_CFG_LAST       15'h7FFF
`define FPG_REG_STATUS     8'h00
`define FPG_REG_CLEAR      8'h04
`define FPG_REG_ENABLE     8'h08
`define FPG_REG_SETTINGS   8'h0C
`define FPG_REG_CONTROL    8'h10
`define FPG_BIT_WRITE_ERROR_FLAG      0
`define FPG_BIT_EXECV      1
`define FPG_BIT_CFGERR     2
`define FPG_BIT_EXECV_N    0
`define FPG_CONTROL_RST    1'b1
`define FPG_VIOL_RST_CYC   16
`endif

// ===== rtl/fpg_pkg.sv
// Types shared by the flash partition guard.
package fpg_pkg;
  typedef struct packed {
    logic       bootEnableN;
    logic       storageEnableN;
    logic [2:0] bootSize;
    logic       appWriteProtect;
    logic       bootWriteProtect;
    logic       configWriteProtect;
  } fpg_settings_t;

  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
  } fpg_access_t;

  typedef enum logic [2:0] {
    FPG_REGION_APP   = 3'h1,
    FPG_REGION_BOOT  = 3'h2,
    FPG_REGION_STORE = 3'h4
  } fpg_region_t;

  typedef enum logic [2:0] {
    FPG_ST_LATCH = 3'h1,
    FPG_ST_RUN   = 3'h2,
    FPG_ST_VIOL  = 3'h4
  } fpg_state_t;
endpackage

// ===== rtl/flash_partition_guard.sv
// Flash partition guard: region decode, write protection and fetch checking.
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`include "fpg_cfg.svh"
module flash_partition_guard #(
  parameter int          ADDR_W      = `FPG_ADDR_W,
  parameter logic [14:0] PFM_LAST    = `FPG_PFM_LAST,
  parameter logic [14:0] CFG_BASE    = `FPG_CFG_BASE,
  parameter logic [14:0] CFG_LAST    = `FPG_CFG_LAST,
  parameter int          VIOL_CYC    = `FPG_VIOL_RST_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire fpg_pkg::fpg_settings_t cfgSettings,
  input  wire fpg_pkg::fpg_access_t   fetchReq,
  input  wire fpg_pkg::fpg_access_t   nvWriteReq,
  output logic                       nvWriteGrant,
  output logic                       execViolationReset,
  output logic                       settingsReady,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  output logic                       irq
);
  fpg_pkg::fpg_settings_t settings;
  fpg_pkg::fpg_state_t    state;
  logic [2:0]  status;
  logic [2:0]  irqEnable;
  logic        execViolationFlagN;
  logic [7:0]  violCount;

  // Boot block end for each size code; sizes are powers of two from 512 words.
  function automatic logic [14:0] boot_last(input logic [2:0] size);
    logic [14:0] words;
    words = 15'h0200 << size;
    return 15'(words - 15'h0001);
  endfunction

  // Region lookup used by the write check only; the fetch check decodes its own window.
  function automatic fpg_pkg::fpg_region_t region_of(
      input logic [14:0] a, input logic [14:0] bootEnd,
      input logic bootOn, input logic storeOn);
    fpg_pkg::fpg_region_t r;
    r = fpg_pkg::FPG_REGION_APP;
    if (bootOn && a <= bootEnd) begin
      r = fpg_pkg::FPG_REGION_BOOT;
    end else if (storeOn && a >= 15'(PFM_LAST - `FPG_STORE_TOP_OFS)) begin
      r = fpg_pkg::FPG_REGION_STORE;
    end
    return r;
  endfunction

  wire         bootOn   = ~settings.bootEnableN;
  wire         storeOn  = ~settings.storageEnableN;
  wire [14:0]  bootEnd  = boot_last(settings.bootSize);
  wire [14:0]  appStart = bootOn ? 15'(bootEnd + 15'h0001) : `FPG_BOOT_START;
  wire [14:0]  appEnd   = storeOn ? 15'(PFM_LAST - `FPG_STORE_SPAN) : PFM_LAST;
  wire         running  = (state == fpg_pkg::FPG_ST_RUN);

  wire fetchInPfm  = fetchReq.addr <= PFM_LAST;
  wire fetchInApp  = fetchInPfm && fetchReq.addr >= appStart && fetchReq.addr <= appEnd;
  wire fetchInBoot = bootOn && fetchReq.addr <= bootEnd;
  // Storage lies above appEnd, so it is in the legal fetch window only when a boot size code of 4 or more covers it.
  wire fetchLegal  = fetchInApp || fetchInBoot;
  wire fetchBad    = running && fetchReq.valid && !fetchLegal;

  fpg_pkg::fpg_region_t wrRegion;
  assign wrRegion = region_of(nvWriteReq.addr, bootEnd, bootOn, storeOn);
  wire wrIsCfg  = nvWriteReq.addr >= CFG_BASE && nvWriteReq.addr <= CFG_LAST;
  wire wrInPfm  = nvWriteReq.addr <= PFM_LAST;
  wire wrBlocked = wrIsCfg ? settings.configWriteProtect :
                   !wrInPfm ? 1'b1 :
                   (wrRegion == fpg_pkg::FPG_REGION_BOOT) ? settings.bootWriteProtect :
                   settings.appWriteProtect;
  // Storage region belongs to the application fuse as it lies in the same array.
  wire wrAttempt = running && nvWriteReq.valid;
  assign nvWriteGrant = wrAttempt && !wrBlocked;
  wire wrError   = wrAttempt && wrBlocked;

  // Bus decode.
  wire busReq    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hitStatus = wb_adr_i == `FPG_REG_STATUS;
  wire hitClear  = wb_adr_i == `FPG_REG_CLEAR;
  wire hitEnable = wb_adr_i == `FPG_REG_ENABLE;
  wire hitSet    = wb_adr_i == `FPG_REG_SETTINGS;
  wire hitCtrl   = wb_adr_i == `FPG_REG_CONTROL;
  wire hitAny    = hitStatus | hitClear | hitEnable | hitSet | hitCtrl;
  // Writes commit in the cycle in which ack stands, at the edge where the master samples it.
  wire wrLane0   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire clearHit  = wrLane0 && hitClear;
  wire [2:0] clearMask = clearHit ? wb_dat_i[2:0] : 3'h0;
  wire [2:0] events;
  assign events[`FPG_BIT_WRITE_ERROR_FLAG]  = wrError;
  assign events[`FPG_BIT_EXECV]  = fetchBad;
  assign events[`FPG_BIT_CFGERR] = 1'b0;
  // Set wins over clear so an event in the clearing cycle survives.
  wire [2:0] next_status = (status & ~clearMask) | events;

  wire [31:0] rdData =
      hitStatus ? {29'h0, status} :
      hitEnable ? {29'h0, irqEnable} :
      hitSet    ? {24'h0, settings} :
      hitCtrl   ? {31'h0, execViolationFlagN} : 32'h0;

  assign irq = |(status & irqEnable);
  assign execViolationReset = (state == fpg_pkg::FPG_ST_VIOL);
  assign settingsReady = running;

  // Settings captured once on the first edge after reset release.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      settings <= '1;
    end else if (state == fpg_pkg::FPG_ST_LATCH) begin
      settings <= cfgSettings;
    end
  end

  // A violation holds the reset output for a fixed time, then resumes.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= fpg_pkg::FPG_ST_LATCH;
      violCount <= 8'h00;
    end else begin
      case (state)
        fpg_pkg::FPG_ST_LATCH: begin
          state <= fpg_pkg::FPG_ST_RUN;
        end
        fpg_pkg::FPG_ST_RUN: begin
          if (fetchBad) begin
            state     <= fpg_pkg::FPG_ST_VIOL;
            violCount <= 8'(VIOL_CYC - 1);
          end
        end
        fpg_pkg::FPG_ST_VIOL: begin
          if (violCount == 8'h00) begin
            state <= fpg_pkg::FPG_ST_RUN;
          end else begin
            violCount <= 8'(violCount - 8'h01);
          end
        end
        default: begin
          state <= fpg_pkg::FPG_ST_LATCH;
        end
      endcase
    end
  end

  // Active-low violation flag: cleared by the reset, set again by software.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      execViolationFlagN <= `FPG_CONTROL_RST;
    end else if (fetchBad) begin
      execViolationFlagN <= 1'b0;
    end else if (wrLane0 && hitCtrl && wb_dat_i[`FPG_BIT_EXECV_N]) begin
      execViolationFlagN <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status    <= 3'h0;
      irqEnable <= 3'h0;
    end else begin
      status <= next_status;
      if (wrLane0 && hitEnable) begin
        irqEnable <= wb_dat_i[2:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busReq && hitAny;
      wb_err_o <= busReq && !hitAny;
      wb_dat_o <= (busReq && !wb_we_i) ? rdData : 32'h0;
    end
  end
endmodule

// ===== verif/fpg_monitor.sv
// Checker for the flash partition guard ports.
module fpg_monitor #(
  parameter logic [14:0] PFM_LAST = 15'h1FFF,
  parameter logic [14:0] CFG_BASE = 15'h7FF0
) (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire logic                   settingsReady,
  input wire logic                   nvWriteGrant,
  input wire logic                   execViolationReset,
  input wire fpg_pkg::fpg_settings_t cfgSettings,
  input wire fpg_pkg::fpg_access_t   fetchReq,
  input wire fpg_pkg::fpg_access_t   nvWriteReq
);
  fpg_pkg::fpg_settings_t lat;
  logic                   got, fv, wv, inBoot;
  logic [14:0]            fa, wa, appEnd;
  assign fa = fetchReq.addr;
  assign wa = nvWriteReq.addr;
  assign fv = fetchReq.valid && settingsReady;
  assign wv = nvWriteReq.valid && settingsReady;
  assign appEnd = lat.storageEnableN ? PFM_LAST : PFM_LAST - 15'h0080;
  assign inBoot = !lat.bootEnableN && wa <= PFM_LAST && {2'h0, wa} < (17'h00200 << lat.bootSize);
  // Own copy of the latched word, so later input changes cannot hide a stale latch.
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) got <= 1'b0;
    else got <= 1'b1;
  always_ff @(posedge core_clk)
    if (!got) lat <= cfgSettings;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_bad_fetch: assert property (fv && fa > appEnd |=> execViolationReset)
    else $error("no reset after bad fetch");
  a_good_fetch: assert property (fv && fa <= appEnd |=> !execViolationReset)
    else $error("reset after legal fetch");
  a_viol_length: assert property ($rose(execViolationReset) |-> ##15 execViolationReset
    ##1 !execViolationReset)
    else $error("violation reset length wrong");
  a_viol_ready: assert property (execViolationReset |-> !settingsReady)
    else $error("ready during violation reset");
  a_boot_write: assert property (wv && inBoot |-> nvWriteGrant == !lat.bootWriteProtect)
    else $error("boot write grant wrong");
  a_app_write: assert property (wv && !inBoot && wa <= PFM_LAST |->
    nvWriteGrant == !lat.appWriteProtect) else $error("app write grant wrong");
  a_cfg_write: assert property (wv && wa >= CFG_BASE |->
    nvWriteGrant == !lat.configWriteProtect) else $error("config write grant wrong");
  a_gap_write: assert property (wv && wa > PFM_LAST && wa < CFG_BASE |-> !nvWriteGrant)
    else $error("write outside flash granted");
endmodule
bind flash_partition_guard fpg_monitor #(.PFM_LAST(PFM_LAST), .CFG_BASE(CFG_BASE)) u_fpg_monitor (
  .core_clk, .arst_n, .settingsReady, .nvWriteGrant, .execViolationReset, .cfgSettings,
  .fetchReq, .nvWriteReq);

// ===== verif/fpg_far_end.sv
// Far-side model: the core fetch path and the nonvolatile write source.
module fpg_far_end (
  input  wire logic            core_clk,
  input  wire logic            nvWriteGrant,
  output fpg_pkg::fpg_access_t fetchReq,
  output fpg_pkg::fpg_access_t nvWriteReq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fetchReq = '0;
    nvWriteReq = '0;
  end
  // One request a call, held one cycle; idle addresses are inverted so none is reused.
  task automatic issue(input logic w, input logic [14:0] a, output logic g);
    @(posedge core_clk);
    if (w)
      nvWriteReq <= {1'b1, a};
    else
      fetchReq <= {1'b1, a};
    #1 g = nvWriteGrant;
    @(posedge core_clk);
    fetchReq <= {1'b0, ~a};
    nvWriteReq <= {1'b0, ~a};
  endtask
endmodule

// ===== verif/flash_partition_guard_test.sv
// Self-checking bench for the flash partition guard.
module flash_partition_guard_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   core_clk = 0, arst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
  logic                   nvWriteGrant, execViolationReset, settingsReady, wbAck, wbErr, irq;
  logic                   g, e, blk;
  logic [7:0]             wbAdr = '0;
  logic [31:0]            wbDat = '0, wbDatOut, q;
  fpg_pkg::fpg_settings_t cfgSettings = '1, lat;
  fpg_pkg::fpg_access_t   fetchReq, nvWriteReq;
  int                     n_mismatch = 0, cmp_count = 0, cyc = 0, be, ae, adr[9];
  int unsigned            seed = 57;
  always #5 core_clk = ~core_clk;
  flash_partition_guard u_flash_partition_guard (.core_clk, .arst_n, .cfgSettings, .fetchReq,
    .nvWriteReq, .nvWriteGrant, .execViolationReset, .settingsReady, .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(4'hF),
    .wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .wb_err_o(wbErr), .irq);
  fpg_far_end u_fpg_far_end (.core_clk, .nvWriteGrant, .fetchReq, .nvWriteReq);
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic grant_of(int a);
    if (a >= 'h7FF0) return !lat.configWriteProtect;
    if (a > 'h1FFF) return 1'b0;
    if (a <= be) return !lat.bootWriteProtect;
    return !lat.appWriteProtect;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= d;
    @(posedge core_clk);
    while (!(wbAck || wbErr)) @(posedge core_clk);
    q = wbDatOut;
    e = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    for (int k = 0; k < 4; k++) begin
      lat = 8'(xs());
      lat.bootEnableN = k[0];
      lat.storageEnableN = k[1];
      lat.bootSize[2] = 1'b0;
      arst_n <= 1'b0;
      cfgSettings <= lat;
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      cfgSettings <= ~lat;
      be = lat.bootEnableN ? -1 : ('h200 << lat.bootSize) - 1;
      ae = lat.storageEnableN ? 'h1FFF : 'h1F7F;
      adr = '{0, be & 'h7FFF, be + 1, ae, ae + 1, 'h1FFF, 'h2000, 'h7FF0, xs() & 'h7FFF};
      wb(1'b1, 8'h08, 32'h1);
      blk = 1'b0;
      foreach (adr[i]) begin
        u_fpg_far_end.issue(1'b1, adr[i][14:0], g);
        check(g, grant_of(adr[i]));
        blk |= !grant_of(adr[i]);
      end
      wb(1'b0, 8'h00, '0);
      check(q[0], blk);
      check(irq, blk);
      wb(1'b1, 8'h08, '0);
      #1 check(irq, 1'b0);
      wb(1'b1, 8'h04, 32'h1);
      wb(1'b0, 8'h0C, '0);
      check(q, {24'h0, lat});
      wb(1'b0, 8'h40, '0);
      check(e, 1'b1);
      foreach (adr[i]) if (adr[i] <= ae) begin
        u_fpg_far_end.issue(1'b0, adr[i][14:0], g);
        #1 check(execViolationReset, 1'b0);
      end
      u_fpg_far_end.issue(1'b0, ae[14:0] + 15'h0001, g);
      #1 check(execViolationReset, 1'b1);
      repeat (15) @(posedge core_clk);
      #1 check(execViolationReset, 1'b1);
      @(posedge core_clk);
      #1 check(execViolationReset, 1'b0);
      wb(1'b0, 8'h10, '0);
      check(q[0], 1'b0);
      wb(1'b0, 8'h00, '0);
      check(q[1:0], 2'h2);
      wb(1'b1, 8'h10, 32'h1);
      wb(1'b0, 8'h10, '0);
      check(q[0], 1'b1);
      $display("config %0d done", k);
    end
    finish_test();
  end
endmodule
